// file: fsu_consts.svh
/*
 * Constants of the flyback start-up and line sensing core: register
 * offsets, reset values, analog codes and timing figures.
 * Assumes 12-bit ADC codes at 1 mV per step and a 100 ns clock.
 */
`ifndef FSU_CONSTS_SVH
`define FSU_CONSTS_SVH
`define FSU_CLK_NS 100
`define FSU_T_REP_NS 52000
`define FSU_WIN50_US 10600
`define FSU_WIN60_US 12700
`define FSU_RESTART_US 200000
`define FSU_FAST_US 25000
`define FSU_ADDR_CTRL 8'h00
`define FSU_ADDR_STATUS 8'h04
`define FSU_ADDR_LINE 8'h08
`define FSU_ADDR_CLAMP 8'h0c
`define FSU_ADDR_CFG 8'h10
`define FSU_CTRL_RST 7'h02
`define FSU_RUN_RES_MIN 8'h1b
`define FSU_PROBE_RES_MAX 8'h44
`define FSU_LINE_OV 12'h7d0
`define FSU_LINE_SHORT 12'h0c8
`define FSU_BROWNIN 12'h1f4
`define FSU_ZC_RISE 12'h037
`define FSU_ZC_FALL 12'h02d
`define FSU_RESP_OKAY 2'b00
`define FSU_RESP_SLVERR 2'b10
`endif

// file: fsu_pkg.sv
/*
 * Types of the flyback start-up and line sensing core.
 * Assumes the widths fixed in fsu_consts.svh.
 */
package fsu_pkg;
    typedef enum logic [2:0] {
        FSU_LOCKOUT, FSU_PRE_RUN, FSU_PRE_PROBE, FSU_PRE_EVAL,
        FSU_SOFT, FSU_RUN, FSU_RESTART
    } fsu_state_t;
    typedef struct packed {
        fsu_state_t state;
        logic [21:0] timer;
        logic [1:0] kind;
        logic [17:0] win_cnt;
        logic [11:0] lmax, lmin, lavg;
        logic avg_ok, line_low, ov, shrt, bi;
        logic [21:0] short_cnt;
        logic [7:0] run_res, probe_res;
        logic [2:0] s1, s2, s3, sup;
        logic burst_chg, zc_lvl, vwait, sw_on;
        logic [5:0] zc_cnt;
        logic [15:0] zc_since, zc_per;
        logic [11:0] cpos, cneg;
        logic [12:0] csum;
        logic [6:0] ctrl;
        logic aw_got, w_got, w_strb0, bvalid, rvalid;
        logic [7:0] aw_addr;
        logic [6:0] w_data;
        logic [1:0] bresp, rresp;
        logic [31:0] rdata;
    } fsu_regs_t;
endpackage : fsu_pkg

// file: fsu_core.sv
/*
 * Start-up sequencer, line averaging and valley counting of a flyback
 * controller, with an AXI4-Lite register slave.
 * Assumes ADC samples and valid strobes on aclk; comparator levels and
 * events from other clock sources arrive on the *_raw inputs.
 */
`timescale 1ns/100ps
`default_nettype none
`include "fsu_consts.svh"
module fsu_core
    import fsu_pkg::*;
#(
    parameter int WIN50_CYC = `FSU_WIN50_US * 1000 / `FSU_CLK_NS,
    parameter int WIN60_CYC = `FSU_WIN60_US * 1000 / `FSU_CLK_NS,
    parameter int RESTART_CYC = `FSU_RESTART_US * 1000 / `FSU_CLK_NS,
    parameter int FAST_CYC = `FSU_FAST_US * 1000 / `FSU_CLK_NS,
    parameter int BLANK_CYC = 100,
    parameter int SOFT_CYC = 1000
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic supply_on_raw,
    input wire logic supply_wake_raw,
    input wire logic supply_burst_raw,
    input wire logic temp_ok,
    input wire logic prot_fire,
    input wire logic burst_mode,
    input wire logic line_synced,
    input wire logic line_is_60,
    input wire logic [11:0] line_sample,
    input wire logic line_valid,
    input wire logic [7:0] config_res_sample,
    input wire logic config_res_valid,
    input wire logic [11:0] valley_sample,
    input wire logic valley_valid,
    input wire logic gate_off,
    input wire logic [11:0] clamp_pos_sample,
    input wire logic [11:0] clamp_neg_sample,
    input wire logic clamp_valid,
    output logic run_pullup_en,
    output logic probe_pullup_en,
    output logic reduced_drive_sel,
    output logic gate_enable,
    output logic low_power_req,
    output logic feedback_sense_en,
    output logic switch_on,
    output logic [11:0] line_average_level,
    output logic [12:0] peak_to_peak_clamp_current
);
    localparam int REP_CYC = `FSU_T_REP_NS / `FSU_CLK_NS;

    fsu_regs_t s_q;
    fsu_regs_t s_d;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic aw_h;
        logic w_h;
        logic act;
        logic win_end;
        logic pe;
        logic short_evt;
        logic xing;
        logic real_x;
        logic [12:0] sum13;
        logic [11:0] avg_new;
        logic [21:0] win_len;
        logic [7:0] wa;
        logic [6:0] wd;
        aw_h = 1'b0;
        w_h = 1'b0;
        act = 1'b0;
        win_end = 1'b0;
        pe = 1'b0;
        short_evt = 1'b0;
        xing = 1'b0;
        real_x = 1'b0;
        sum13 = 13'h0000;
        avg_new = 12'h000;
        win_len = 22'h000000;
        wa = 8'h00;
        wd = 7'h00;
        s_d = s_q;
        s_d.sw_on = 1'b0;

        // Three-stage catch; a level counts once stages two and three agree.
        s_d.s1 = {supply_burst_raw, supply_wake_raw, supply_on_raw};
        s_d.s2 = s_q.s1;
        s_d.s3 = s_q.s2;
        for (int i = 0; i < 3; i++) begin
            if (s_q.s2[i] == s_q.s3[i]) begin
                s_d.sup[i] = s_q.s3[i];
            end
        end

        act = (s_q.state != FSU_LOCKOUT) && (s_q.state != FSU_RESTART);

        // ------------------------------------------------------------
        // Line window and averaging
        // ------------------------------------------------------------
        // window length select.
        if (line_synced && line_is_60) begin
            win_len = 22'(WIN60_CYC);
        end else begin
            win_len = 22'(WIN50_CYC);
        end
        if (line_valid) begin
            if (line_sample > s_q.lmax) begin
                s_d.lmax = line_sample;
            end
            if (line_sample < s_q.lmin) begin
                s_d.lmin = line_sample;
            end
            if (act && line_sample > `FSU_LINE_OV) begin
                s_d.ov = 1'b1;
            end
            s_d.line_low = line_sample < `FSU_LINE_SHORT;
        end
        s_d.win_cnt = s_q.win_cnt + 18'h00001;
        win_end = 22'(s_q.win_cnt) >= win_len - 22'h000001;
        sum13 = {1'b0, s_q.lmax} + {1'b0, s_q.lmin};
        avg_new = sum13[12:1];
        if (win_end) begin
            s_d.win_cnt = 18'h00000;
            s_d.lmax = 12'h000;
            s_d.lmin = 12'hfff;
            s_d.lavg = avg_new;
            s_d.avg_ok = 1'b1;
        end

        if (s_q.line_low && act) begin
            if (s_q.short_cnt != 22'h3fffff) begin
                s_d.short_cnt = s_q.short_cnt + 22'h000001;
            end
        end else begin
            s_d.short_cnt = 22'h000000;
        end
        short_evt = act && (s_q.short_cnt > 22'(BLANK_CYC));

        pe = act && (prot_fire || s_q.ov || short_evt
            || (win_end && s_q.state >= FSU_SOFT
                && avg_new < `FSU_BROWNIN));

        // ------------------------------------------------------------
        // Start-up sequencer
        // ------------------------------------------------------------
        case (s_q.state)
            FSU_LOCKOUT: begin
                if (s_q.sup[0]) begin
                    s_d.state = FSU_PRE_RUN;
                    s_d.ov = 1'b0;
                    s_d.shrt = 1'b0;
                    s_d.bi = 1'b0;
                end
            end
            FSU_PRE_RUN: begin
                if (config_res_valid) begin
                    s_d.run_res = config_res_sample;
                    s_d.state = FSU_PRE_PROBE;
                end
            end
            FSU_PRE_PROBE: begin
                if (config_res_valid) begin
                    s_d.probe_res = config_res_sample;
                    s_d.state = FSU_PRE_EVAL;
                end
            end
            FSU_PRE_EVAL: begin
                if (s_q.ctrl[0] && temp_ok && s_q.avg_ok
                    && s_q.lavg >= `FSU_BROWNIN) begin
                    s_d.state = FSU_SOFT;
                    s_d.timer = 22'(SOFT_CYC);
                end
            end
            FSU_SOFT: begin
                s_d.timer = s_q.timer - 22'h000001;
                if (s_q.timer == 22'h000000) begin
                    s_d.state = FSU_RUN;
                end
            end
            FSU_RUN: begin
                if (burst_mode && !s_q.sup[1]) begin
                    s_d.burst_chg = 1'b1;
                end else if (!burst_mode || s_q.sup[2]) begin
                    s_d.burst_chg = 1'b0;
                end
            end
            FSU_RESTART: begin
                s_d.timer = s_q.timer - 22'h000001;
                if (s_q.timer == 22'h000000) begin
                    if (s_q.kind == 2'd1 && s_q.line_low) begin
                        s_d.bi = 1'b1;
                        s_d.kind = 2'd2;
                        s_d.timer = 22'(FAST_CYC);
                    end else begin
                        s_d.state = FSU_LOCKOUT;
                    end
                end
            end
            default: begin
                s_d.state = FSU_LOCKOUT;
            end
        endcase
        if (pe) begin
            s_d.state = FSU_RESTART;
            s_d.timer = 22'(RESTART_CYC);
            s_d.kind = {1'b0, short_evt};
            s_d.shrt = s_q.shrt | short_evt;
            s_d.burst_chg = 1'b0;
        end

        // ------------------------------------------------------------
        // Valley counting and clamp capture
        // ------------------------------------------------------------
        // hysteresis on the crossing level.
        if (valley_valid) begin
            if (valley_sample > `FSU_ZC_RISE) begin
                s_d.zc_lvl = 1'b1;
            end else if (valley_sample < `FSU_ZC_FALL) begin
                s_d.zc_lvl = 1'b0;
            end
        end
        real_x = s_q.zc_lvl && !s_d.zc_lvl;
        if (s_q.zc_since != 16'hffff) begin
            s_d.zc_since = s_q.zc_since + 16'h0001;
        end
        if (gate_off) begin
            s_d.vwait = 1'b1;
            s_d.zc_cnt = 6'h00;
            s_d.zc_since = 16'h0000;
        end else if (s_q.vwait && gate_enable) begin
            xing = real_x || (s_q.zc_cnt != 6'h00
                && s_q.zc_per != 16'h0000
                && s_q.zc_since >= s_q.zc_per);
            if (xing) begin
                s_d.zc_cnt = s_q.zc_cnt + 6'h01;
                s_d.zc_since = 16'h0000;
                if (real_x && s_q.zc_cnt != 6'h00) begin
                    s_d.zc_per = s_q.zc_since;
                end
                if (s_q.zc_cnt + 6'h01 >= s_q.ctrl[6:1]) begin
                    s_d.sw_on = 1'b1;
                    s_d.vwait = 1'b0;
                end
            end else if (s_q.zc_cnt == 6'h00
                && s_q.zc_since >= 16'(REP_CYC - 1)) begin
                // repeat timer when no crossing is seen.
                s_d.sw_on = 1'b1;
                s_d.vwait = 1'b0;
            end
        end

        if (clamp_valid) begin
            s_d.cpos = clamp_pos_sample;
            s_d.cneg = clamp_neg_sample;
            s_d.csum = {1'b0, clamp_pos_sample}
                + {1'b0, clamp_neg_sample};
        end

        // ------------------------------------------------------------
        // AXI4-Lite slave
        // ------------------------------------------------------------
        aw_h = s_axi_awvalid && s_axi_awready;
        w_h = s_axi_wvalid && s_axi_wready;
        if (aw_h) begin
            s_d.aw_got = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (w_h) begin
            s_d.w_got = 1'b1;
            s_d.w_data = s_axi_wdata[6:0];
            s_d.w_strb0 = s_axi_wstrb[0];
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        if ((s_q.aw_got || aw_h) && (s_q.w_got || w_h) && !s_q.bvalid) begin
            wa = aw_h ? s_axi_awaddr : s_q.aw_addr;
            wd = w_h ? s_axi_wdata[6:0] : s_q.w_data;
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = `FSU_RESP_OKAY;
            if (wa == `FSU_ADDR_CTRL) begin
                if (w_h ? s_axi_wstrb[0] : s_q.w_strb0) begin
                    s_d.ctrl = wd;
                end
            end else if (wa != `FSU_ADDR_STATUS && wa != `FSU_ADDR_LINE
                && wa != `FSU_ADDR_CLAMP && wa != `FSU_ADDR_CFG) begin
                s_d.bresp = `FSU_RESP_SLVERR;
            end
        end
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = `FSU_RESP_OKAY;
            case (s_axi_araddr)
                `FSU_ADDR_CTRL: s_d.rdata = {25'h0000000, s_q.ctrl};
                `FSU_ADDR_STATUS: s_d.rdata = {22'h000000, s_q.burst_chg,
                    s_q.avg_ok, s_q.probe_res <= `FSU_PROBE_RES_MAX,
                    feedback_sense_en, s_q.bi, s_q.shrt, s_q.ov,
                    s_q.state};
                `FSU_ADDR_LINE: s_d.rdata = {20'h00000, s_q.lavg};
                `FSU_ADDR_CLAMP: s_d.rdata = {7'h00, s_q.csum,
                    s_q.cneg[5:0], s_q.cpos[5:0]};
                `FSU_ADDR_CFG: s_d.rdata = {16'h0000, s_q.probe_res,
                    s_q.run_res};
                default: begin
                    s_d.rdata = 32'h00000000;
                    s_d.rresp = `FSU_RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
            s_q.state <= FSU_LOCKOUT;
            s_q.lmin <= 12'hfff;
            s_q.ctrl <= `FSU_CTRL_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Handshake readies are combinational so a write takes two cycles.
    assign s_axi_awready = !s_q.aw_got && !s_q.bvalid;
    assign s_axi_wready = !s_q.w_got && !s_q.bvalid;
    assign s_axi_arready = !s_q.rvalid;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign run_pullup_en = s_q.state == FSU_PRE_RUN
        || s_q.state == FSU_SOFT
        || (s_q.state == FSU_RUN && !s_q.burst_chg);
    assign probe_pullup_en = s_q.state == FSU_PRE_PROBE;
    // reduced drive outside the run state and in burst mode.
    assign reduced_drive_sel = s_q.state != FSU_RUN || burst_mode;
    assign gate_enable = (s_q.state == FSU_SOFT || s_q.state == FSU_RUN)
        && !s_q.line_low;
    assign low_power_req = s_q.shrt || s_q.bi || s_q.line_low;
    assign feedback_sense_en = s_q.state == FSU_RUN
        && s_q.run_res >= `FSU_RUN_RES_MIN;
    assign switch_on = s_q.sw_on;
    assign line_average_level = s_q.lavg;
    assign peak_to_peak_clamp_current = s_q.csum;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    logic act_q;
    assign act_q = s_q.state != FSU_LOCKOUT && s_q.state != FSU_RESTART;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_lockout_pullup: assert property (s_q.state == FSU_LOCKOUT
        |-> !run_pullup_en && !probe_pullup_en)
        else $error("pull-up on in lockout");
    a_probe_after_run: assert property (s_q.state == FSU_PRE_PROBE
        && $past(s_q.state) != FSU_PRE_PROBE
        |-> $past(run_pullup_en) && probe_pullup_en)
        else $error("probe pull-up out of order");
    a_start_cond: assert property (s_q.state == FSU_SOFT
        && $past(s_q.state) == FSU_PRE_EVAL
        |-> $past(temp_ok) && $past(s_q.ctrl[0]) && $past(s_q.avg_ok)
        && $past(s_q.lavg) >= `FSU_BROWNIN)
        else $error("soft start without conditions");
    a_run_entry: assert property (s_q.state == FSU_RUN
        && $past(s_q.state) != FSU_RUN
        |-> $past(s_q.state) == FSU_SOFT)
        else $error("run entered not from soft start");
    a_reduced_drive: assert property (s_q.state != FSU_RUN
        |-> reduced_drive_sel)
        else $error("full drive during start-up");
    a_soft_pullup: assert property (s_q.state == FSU_SOFT
        |-> run_pullup_en ##1 (s_q.state != FSU_SOFT
        || run_pullup_en))
        else $error("run pull-up off in soft start");
    a_restart_lock: assert property (s_q.state == FSU_RESTART
        && s_q.timer == 22'h000000 && s_q.kind != 2'd1
        |=> s_q.state == FSU_LOCKOUT)
        else $error("restart did not reach lockout");
    a_fb_sense: assert property (feedback_sense_en
        |-> s_q.run_res >= `FSU_RUN_RES_MIN)
        else $error("feedback sensing below threshold");
    a_line_ov: assert property (line_valid && act_q
        && line_sample > `FSU_LINE_OV ##1 s_q.state != FSU_LOCKOUT
        |-> s_q.ov)
        else $error("overvoltage not flagged");
    a_short_gate: assert property (s_q.line_low
        |-> !gate_enable && low_power_req)
        else $error("gate enabled with line short");
    a_clamp_sum: assert property (clamp_valid |=> s_q.csum
        == {1'b0, $past(clamp_pos_sample)}
        + {1'b0, $past(clamp_neg_sample)})
        else $error("clamp sum wrong");

    c_run: cover property (s_q.state == FSU_SOFT ##1 s_q.state == FSU_RUN);
    c_restart: cover property (s_q.state == FSU_RESTART
        && s_q.kind == 2'd2);
    c_switch: cover property (switch_on && s_q.zc_cnt > 6'h01);
endmodule : fsu_core
`default_nettype wire

// file: fsu_tail_note.sv
`timescale 1ns/100ps

// file: fsu_plant.sv
/*
 * Stand-in for the power stage: line divider, configuration resistor,
 * clamp currents and supply comparators seen by the core.
 * Assumes the core's pull-up enables and a free-running aclk.
 */
`timescale 1ns/100ps
`default_nettype none
module fsu_plant #(
    parameter logic [7:0] RUN_RES = 8'h1e,
    parameter logic [7:0] PROBE_RES = 8'h32
) (
    input wire logic aclk,
    input wire logic run_pullup_en,
    input wire logic probe_pullup_en,
    input wire logic vcc_dip,
    input wire logic [11:0] line_hi,
    input wire logic [11:0] line_lo,
    output logic supply_wake_raw,
    output logic supply_burst_raw,
    output logic [11:0] line_sample,
    output logic line_valid,
    output logic [7:0] config_res_sample,
    output logic config_res_valid,
    output logic [11:0] clamp_pos_sample,
    output logic [11:0] clamp_neg_sample,
    output logic clamp_valid
);
    logic [7:0] cnt_q = 8'h00;
    always @(posedge aclk) begin
        cnt_q <= cnt_q + 8'h01;
    end
    // A supply dip takes both comparators below their levels at once.
    assign supply_wake_raw = !vcc_dip;
    assign supply_burst_raw = !vcc_dip;
    // Between strobes the lines carry junk, never the last value.
    assign line_valid = (cnt_q[1:0] == 2'h3);
    assign line_sample = !line_valid ? {4'h0, ~cnt_q} :
        (cnt_q[2] ? line_hi : line_lo);
    // Resistance can only be measured while a pull-up is switched on.
    assign config_res_valid = (cnt_q[3:0] == 4'hf) &&
        (run_pullup_en || probe_pullup_en);
    assign config_res_sample = !config_res_valid ? ~cnt_q :
        (probe_pullup_en ? PROBE_RES : RUN_RES);
    assign clamp_valid = (cnt_q[2:0] == 3'h5);
    assign clamp_pos_sample = clamp_valid ? 12'h123 : {4'h0, cnt_q};
    assign clamp_neg_sample = clamp_valid ? 12'h456 : {4'h0, ~cnt_q};
endmodule : fsu_plant
`default_nettype wire

// file: test_flyback_startup_and_line_sensing.sv
/*
 * Self-checking bench for the start-up and line sensing core.
 * Assumes fsu_plant as the power stage and AXI4-Lite register access.
 */
`timescale 1ns/100ps
`default_nettype none
module test_flyback_startup_and_line_sensing
    import fsu_pkg::*;
;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, rdat;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, gate_off = 1'b0;
    logic supply_on_raw = 1'b0, temp_ok = 1'b1, prot_fire = 1'b0;
    logic burst_mode = 1'b0, line_synced = 1'b0, line_is_60 = 1'b0;
    logic [11:0] valley_sample = 12'h0, line_hi = 12'h500, line_lo = 12'h300;
    logic valley_valid = 1'b0, vcc_dip = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, supply_wake_raw, supply_burst_raw, line_valid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_rdata;
    logic [11:0] line_sample, clamp_pos_sample, clamp_neg_sample;
    logic [7:0] config_res_sample;
    logic config_res_valid, clamp_valid, run_pullup_en, probe_pullup_en;
    logic reduced_drive_sel, gate_enable, low_power_req;
    logic feedback_sense_en, switch_on;
    logic [11:0] line_average_level;
    logic [12:0] peak_to_peak_clamp_current;
    int errors = 0, total_checks = 0, n;
    always #50 aclk = ~aclk;
    fsu_core #(.WIN50_CYC(200), .WIN60_CYC(240), .RESTART_CYC(300),
        .FAST_CYC(50), .BLANK_CYC(10), .SOFT_CYC(20)) u_fsu_core (.*);
    fsu_plant u_fsu_plant (.*);
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_awvalid && !s_axi_awready
            || s_axi_wvalid && !s_axi_wready);
        do @(posedge aclk); while (!s_axi_bvalid);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        rdat = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic wst(input logic [2:0] s);
        n = 0;
        do begin
            rd(8'h04);
            n++;
        end while (rdat[2:0] !== s && n < 400);
        chk("state", {29'h0, s}, {29'h0, rdat[2:0]});
    endtask : wst
    task automatic gap(input int lo, input int hi);
        @(posedge aclk);
        gate_off <= 1'b1;
        @(posedge aclk);
        gate_off <= 1'b0;
        for (n = 0; n < 600 && switch_on !== 1'b1; n++) @(posedge aclk);
        chk("valley wait", 1, n >= lo && n <= hi);
    endtask : gap
    task automatic end_of_test;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test
    initial begin
        #2000000;
        errors++;
        end_of_test();
    end
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        wst(3'h0);
        chk("run pullup", 0, run_pullup_en);
        chk("drive", 1, reduced_drive_sel);
        wr(8'h00, 32'h0, 4'he);
        rd(8'h00); chk("ctrl", 32'h2, rdat);
        rd(8'h14); chk("rresp", 2, rsp);
        wr(8'h14, 32'h0, 4'hf); chk("bresp", 2, rsp);
        supply_on_raw <= 1'b1;
        wst(3'h3);
        rd(8'h10); chk("cfg", 32'h321e, rdat);
        wr(8'h00, 32'h3, 4'hf);
        wst(3'h4);
        chk("run pullup", 1, run_pullup_en);
        chk("drive", 1, reduced_drive_sel);
        wst(3'h5);
        chk("fb sense", 1, feedback_sense_en);
        chk("average", 32'h400, line_average_level);
        chk("p2p", 32'h579, peak_to_peak_clamp_current);
        rd(8'h0c); chk("clamp", 32'h5795a3, rdat);
        rd(8'h08);
        chk("line reg", 32'h400, rdat);
        burst_mode <= 1'b1;
        vcc_dip <= 1'b1;
        repeat (8) @(posedge aclk);
        chk("burst pullup", 0, run_pullup_en);
        chk("burst drive", 1, reduced_drive_sel);
        vcc_dip <= 1'b0;
        repeat (8) @(posedge aclk);
        chk("recharged", 1, run_pullup_en);
        burst_mode <= 1'b0;
        gap(518, 522);
        fork
            gap(1, 6);
            begin
                repeat (3) @(posedge aclk);
                valley_valid <= 1'b1;
                valley_sample <= 12'h040;
                @(posedge aclk);
                valley_sample <= 12'h020;
                @(posedge aclk);
                valley_valid <= 1'b0;
            end
        join
        line_hi <= 12'h7d1;
        wst(3'h6); chk("ov", 1, rdat[3]);
        supply_on_raw <= 1'b0;
        line_hi <= 12'h500;
        wst(3'h0);
        chk("pullups", 0, run_pullup_en | probe_pullup_en);
        supply_on_raw <= 1'b1;
        line_hi <= 12'h050;
        line_lo <= 12'h050;
        wst(3'h6); chk("short", 1, rdat[4]);
        chk("gate", 0, gate_enable);
        chk("low power", 1, low_power_req);
        supply_on_raw <= 1'b0;
        wst(3'h0);
        chk("brownin", 1, rdat[5]);
        line_hi <= 12'h500;
        line_lo <= 12'h300;
        temp_ok <= 1'b0;
        line_synced <= 1'b1;
        line_is_60 <= 1'b1;
        supply_on_raw <= 1'b1;
        wst(3'h3);
        repeat (500) @(posedge aclk);
        rd(8'h04);
        chk("hot hold", 3, rdat[2:0]);
        temp_ok <= 1'b1;
        wst(3'h5);
        chk("average 60", 32'h400, line_average_level);
        prot_fire <= 1'b1;
        supply_on_raw <= 1'b0;
        wst(3'h6);
        prot_fire <= 1'b0;
        wst(3'h0);
        chk("lockout pullup", 0, run_pullup_en);
        end_of_test();
    end
endmodule : test_flyback_startup_and_line_sensing
`default_nettype wire
